// file: verilog/adc_mode_pkg.sv
// Shared constants and types for the mode register control block
`default_nettype none
package adc_mode_pkg;
  // ==========================================
  // Widths
  localparam int REG_W = 8;
  localparam int DATA_W = 24;
  localparam int CNT_W = 5;
  // ==========================================
  // Reset and fixed register values
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] STATUS_FIXED = 8'h0c;
  localparam logic [7:0] FILTER_RESET = 8'h04;
  localparam logic [23:0] BIPOLAR_ZERO = 24'h800000;
  localparam logic [15:0] PAD_LOW = 16'h0000;
  // ==========================================
  // Register select codes
  localparam logic [1:0] RS_STATUS = 2'h0;
  localparam logic [1:0] RS_MODE = 2'h1;
  localparam logic [1:0] RS_FILTER = 2'h2;
  localparam logic [1:0] RS_DATA = 2'h3;
  // ==========================================
  // Mode register fields
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int BURNOUT_BIT = 3;
  localparam int POLARITY_BIT = 2;
  localparam int AMP_BIT = 1;
  // ==========================================
  // Communications byte fields
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_READ_BIT = 6;
  localparam int CMD_RS_HI = 5;
  localparam int CMD_RS_LO = 4;
  localparam int CMD_CREAD_BIT = 2;
  // ==========================================
  // Serial bit counts
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
  localparam logic [4:0] LAST_WORD_BIT = 5'h17;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OUT_PERIOD_US = 60000;
  localparam int FIRST_PERIODS = 2;
  // ==========================================
  // Enumerations
  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_RSVD = 2'b01,
    MODE_SINGLE = 2'b10,
    MODE_PDOWN = 2'b11
  } conv_mode_type;
  typedef enum logic [1:0] {
    SER_CMD = 2'b00,
    SER_WR = 2'b01,
    SER_RD = 2'b10
  } ser_state_type;
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_FIRST = 2'b01,
    SEQ_NEXT = 2'b10
  } seq_state_type;
endpackage
`default_nettype wire

// file: verilog/pin_sync.sv
// Two-flop synchronisers for serial pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Raw pins and synchronised levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  // ==========================================
  // Per-bit synchroniser
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          meta_ff <= RESET_VAL[gi];
          sync_ff <= RESET_VAL[gi];
        end
        else
        begin
          meta_ff <= pin_in[gi];
          sync_ff <= meta_ff;
        end
      end
      assign pin_sync_out[gi] = sync_ff;
    end
  endgenerate
endmodule
`default_nettype wire

// file: verilog/conv_timer.sv
// Conversion sequencer timing output-rate periods
`timescale 1ns/100ps
`default_nettype none
module conv_timer #(
  parameter int PERIOD_CYC = 600000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic restart,
  input wire logic run_cont,
  input wire logic run_single,
  // Status
  output logic conv_done,
  output logic powered
);
  localparam int FIRST_CYC = adc_mode_pkg::FIRST_PERIODS * PERIOD_CYC;
  localparam logic [31:0] FIRST_LOAD = 32'(FIRST_CYC - 1);
  localparam logic [31:0] NEXT_LOAD = 32'(PERIOD_CYC - 1);

  adc_mode_pkg::seq_state_type state_ff;
  adc_mode_pkg::seq_state_type nxt_state;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;
  wire cnt_zero = (cnt_ff == 32'h00000000);
  wire running = (state_ff != adc_mode_pkg::SEQ_OFF);

  // ==========================================
  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (restart)
    begin
      nxt_cnt = FIRST_LOAD;
      nxt_state = (run_cont || run_single) ? adc_mode_pkg::SEQ_FIRST : adc_mode_pkg::SEQ_OFF;
    end
    else
    begin
      case (state_ff)
        adc_mode_pkg::SEQ_OFF:
          nxt_cnt = cnt_ff;
        adc_mode_pkg::SEQ_FIRST, adc_mode_pkg::SEQ_NEXT:
          if (cnt_zero)
          begin
            nxt_done = 1'b1;
            nxt_cnt = NEXT_LOAD;
            nxt_state = run_single ? adc_mode_pkg::SEQ_OFF : adc_mode_pkg::SEQ_NEXT;
          end
          else
          begin
            nxt_cnt = cnt_ff - 32'h00000001;
          end
        default:
          nxt_state = adc_mode_pkg::SEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= adc_mode_pkg::SEQ_FIRST;
      cnt_ff <= FIRST_LOAD;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign conv_done = done_ff;
  assign powered = running;

  // ==========================================
  // Checks
  first_wait_a: assert property (@(posedge mclk) disable iff (!rstn)
    restart && run_cont |=> state_ff == adc_mode_pkg::SEQ_FIRST && cnt_ff == FIRST_LOAD)
    else $error("first conversion wait not loaded");
  next_wait_a: assert property (@(posedge mclk) disable iff (!rstn)
    done_ff && state_ff == adc_mode_pkg::SEQ_NEXT && !$past(restart) |-> cnt_ff == NEXT_LOAD)
    else $error("later conversion spacing wrong");
endmodule
`default_nettype wire

// file: verilog/adc_mode_register_control.sv
// Mode register, serial access and conversion control
// Functional notes
// - Mode register uses select code 01 and resets to 0x02.
// - Mode register is eight bits, readable and writable serially.
// - Mode register bits move most significant first.
// - Any mode write resets modulator and filter and sets not-ready.
// - Bits 7 and 6 choose continuous, single or power-down operation.
// - Continuous mode converts back to back, stores result, drives ready low.
// - Continuous read shifts each result out; else host requests each result.
// - First result after two periods, later ones one period apart.
// - Single mode powers up, converts after two periods, then powers down.
// - Single result and low ready held until read or next conversion.
// - Bit 3 switches the burnout current sources on or off.
// - Burnout currents only flow while the input amplifier is enabled.
// - Mode codes: 00 continuous, 01 reserved, 10 single, 11 power-down.
// - Bit 2 set selects unipolar, clear selects offset binary bipolar.
// - Bit 1 clear gives unbuffered input, set gives buffered input.
`timescale 1ns/100ps
`default_nettype none
module adc_mode_register_control #(
  parameter int OUT_PERIOD_US = adc_mode_pkg::OUT_PERIOD_US
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy_n,
  output logic dout_oe_n,
  // Front end sample
  input wire logic [23:0] adc_sample,
  // Front end control
  output logic modulator_reset,
  output logic converter_powered,
  output logic buffer_enable,
  output logic unipolar_enable,
  output logic burnout_current_enable,
  output logic conv_mode_sel_hi,
  output logic conv_mode_sel_lo,
  output logic data_ready_n
);
  localparam int PERIOD_CYC = OUT_PERIOD_US * 1000 / adc_mode_pkg::CLK_PERIOD_NS;

  // ==========================================
  // Pin synchronisers
  logic [2:0] pins_s;
  wire sclk_s = pins_s[2];
  wire cs_n_s = pins_s[1];
  wire din_s = pins_s[0];

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h6)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pin_in({sclk, cs_n, din}),
    .pin_sync_out(pins_s)
  );

  // ==========================================
  // State
  adc_mode_pkg::ser_state_type ser_ff;
  adc_mode_pkg::ser_state_type nxt_ser;
  logic sclk_prev_ff;
  logic [4:0] bit_cnt_ff;
  logic [4:0] nxt_bit_cnt;
  logic [4:0] len_ff;
  logic [4:0] nxt_len;
  logic [7:0] rx_sh_ff;
  logic [23:0] tx_sh_ff;
  logic [23:0] nxt_tx_sh;
  logic [1:0] rs_ff;
  logic [1:0] nxt_rs;
  logic cread_ff;
  logic nxt_cread;
  logic exit_ff;
  logic nxt_exit;
  logic [7:0] mode_ff;
  logic mode_wr_ff;
  logic [23:0] data_ff;
  logic rdy_n_ff;
  logic err_ff;
  logic dout_ff;
  logic conv_done;

  // ==========================================
  // Decode
  wire sel = !cs_n_s;
  wire sclk_rise = sclk_s && !sclk_prev_ff;
  wire sclk_fall = !sclk_s && sclk_prev_ff;
  wire [7:0] rx_byte = {rx_sh_ff[6:0], din_s};
  wire [1:0] cmd_rs = rx_byte[adc_mode_pkg::CMD_RS_HI:adc_mode_pkg::CMD_RS_LO];
  wire cmd_ok = !rx_byte[adc_mode_pkg::CMD_WEN_BIT];
  wire cmd_read = rx_byte[adc_mode_pkg::CMD_READ_BIT];
  wire cmd_cread = rx_byte[adc_mode_pkg::CMD_CREAD_BIT];
  wire byte_end = sclk_rise && (bit_cnt_ff == adc_mode_pkg::LAST_BYTE_BIT);
  wire cmd_done = sel && (ser_ff == adc_mode_pkg::SER_CMD) && byte_end;
  wire wr_done = sel && (ser_ff == adc_mode_pkg::SER_WR) && byte_end;
  wire rd_last = sel && (ser_ff == adc_mode_pkg::SER_RD) && sclk_rise && (bit_cnt_ff == len_ff);
  wire rd_data_done = rd_last && (len_ff == adc_mode_pkg::LAST_WORD_BIT);
  wire mode_wr = wr_done && (rs_ff == adc_mode_pkg::RS_MODE);
  wire conv_ok = conv_done && !mode_wr && !mode_wr_ff;
  wire cread_load = sel && cread_ff && conv_ok && (ser_ff == adc_mode_pkg::SER_CMD)
                    && (bit_cnt_ff == adc_mode_pkg::CNT_ZERO);
  wire cread_exit = cread_ff && byte_end && cmd_ok && !cmd_cread;
  wire [1:0] mode_sel = mode_ff[adc_mode_pkg::MODE_HI_BIT:adc_mode_pkg::MODE_LO_BIT];
  wire run_cont = (mode_sel == adc_mode_pkg::MODE_CONT);
  wire run_single = (mode_sel == adc_mode_pkg::MODE_SINGLE);
  wire unipolar = mode_ff[adc_mode_pkg::POLARITY_BIT];
  wire amp_on = mode_ff[adc_mode_pkg::AMP_BIT];
  wire sample_neg = adc_sample[adc_mode_pkg::DATA_W-1];
  wire [23:0] uni_code = sample_neg ? '0 : {adc_sample[22:0], 1'b0};
  wire [23:0] result_fmt = unipolar ? uni_code : (adc_sample ^ adc_mode_pkg::BIPOLAR_ZERO);
  wire clamp = unipolar && sample_neg;
  wire [7:0] status_byte = {rdy_n_ff, err_ff, adc_mode_pkg::STATUS_FIXED[5:0]};
  wire [7:0] rd_byte = (cmd_rs == adc_mode_pkg::RS_MODE) ? mode_ff :
                       (cmd_rs == adc_mode_pkg::RS_FILTER) ? adc_mode_pkg::FILTER_RESET : status_byte;
  wire [23:0] rd_word = (cmd_rs == adc_mode_pkg::RS_DATA) ? data_ff : {rd_byte, adc_mode_pkg::PAD_LOW};
  wire [4:0] rd_len = (cmd_rs == adc_mode_pkg::RS_DATA) ? adc_mode_pkg::LAST_WORD_BIT :
                      adc_mode_pkg::LAST_BYTE_BIT;
  wire [7:0] nxt_rx = (sel && sclk_rise) ? rx_byte : rx_sh_ff;
  wire [7:0] nxt_mode = mode_wr ? rx_byte : mode_ff;
  wire [23:0] nxt_data = conv_ok ? result_fmt : data_ff;
  wire nxt_rdy_n = conv_ok ? 1'b0 : ((mode_wr || rd_data_done) ? 1'b1 : rdy_n_ff);
  wire nxt_err = conv_ok ? clamp : (mode_wr ? 1'b0 : err_ff);
  wire nxt_dout = (ser_ff == adc_mode_pkg::SER_RD) ? tx_sh_ff[adc_mode_pkg::DATA_W-1] : rdy_n_ff;

  // ==========================================
  // Serial protocol
  always_comb
  begin
    nxt_ser = ser_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_rs = rs_ff;
    nxt_len = len_ff;
    nxt_cread = cread_ff;
    nxt_exit = exit_ff;
    if (!sel)
    begin
      nxt_ser = adc_mode_pkg::SER_CMD;
      nxt_bit_cnt = adc_mode_pkg::CNT_ZERO;
    end
    else
    begin
      case (ser_ff)
        adc_mode_pkg::SER_CMD:
          if (cread_load)
          begin
            nxt_tx_sh = result_fmt;
            nxt_len = adc_mode_pkg::LAST_WORD_BIT;
            nxt_exit = 1'b0;
            nxt_ser = adc_mode_pkg::SER_RD;
          end
          else if (sclk_rise)
          begin
            nxt_bit_cnt = bit_cnt_ff + adc_mode_pkg::CNT_ONE;
            if (cmd_done)
            begin
              nxt_bit_cnt = adc_mode_pkg::CNT_ZERO;
              if (cmd_ok && cmd_read && cmd_cread && (cmd_rs == adc_mode_pkg::RS_DATA))
              begin
                nxt_cread = 1'b1;
              end
              else if (cmd_ok && cmd_read)
              begin
                nxt_tx_sh = rd_word;
                nxt_len = rd_len;
                nxt_exit = 1'b0;
                nxt_ser = adc_mode_pkg::SER_RD;
              end
              else if (cmd_ok)
              begin
                nxt_rs = cmd_rs;
                nxt_ser = adc_mode_pkg::SER_WR;
              end
            end
          end
        adc_mode_pkg::SER_WR:
          if (sclk_rise)
          begin
            nxt_bit_cnt = bit_cnt_ff + adc_mode_pkg::CNT_ONE;
            if (wr_done)
            begin
              nxt_bit_cnt = adc_mode_pkg::CNT_ZERO;
              nxt_ser = adc_mode_pkg::SER_CMD;
            end
          end
        adc_mode_pkg::SER_RD:
          if (sclk_rise)
          begin
            nxt_bit_cnt = bit_cnt_ff + adc_mode_pkg::CNT_ONE;
            if (cread_exit)
            begin
              nxt_exit = 1'b1;
            end
            if (rd_last)
            begin
              nxt_bit_cnt = adc_mode_pkg::CNT_ZERO;
              nxt_ser = adc_mode_pkg::SER_CMD;
              nxt_cread = cread_ff && !exit_ff;
            end
          end
          else if (sclk_fall && (bit_cnt_ff != adc_mode_pkg::CNT_ZERO))
          begin
            nxt_tx_sh = {tx_sh_ff[22:0], 1'b0};
          end
        default:
          nxt_ser = adc_mode_pkg::SER_CMD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ser_ff <= adc_mode_pkg::SER_CMD;
      sclk_prev_ff <= 1'b1;
      bit_cnt_ff <= adc_mode_pkg::CNT_ZERO;
      len_ff <= adc_mode_pkg::LAST_BYTE_BIT;
      rx_sh_ff <= '0;
      tx_sh_ff <= '0;
      rs_ff <= adc_mode_pkg::RS_STATUS;
      cread_ff <= 1'b0;
      exit_ff <= 1'b0;
      dout_ff <= 1'b1;
    end
    else
    begin
      ser_ff <= nxt_ser;
      sclk_prev_ff <= sclk_s;
      bit_cnt_ff <= nxt_bit_cnt;
      len_ff <= nxt_len;
      rx_sh_ff <= nxt_rx;
      tx_sh_ff <= nxt_tx_sh;
      rs_ff <= nxt_rs;
      cread_ff <= nxt_cread;
      exit_ff <= nxt_exit;
      dout_ff <= nxt_dout;
    end
  end

  // ==========================================
  // Mode, data and ready registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_ff <= adc_mode_pkg::MODE_RESET;
      mode_wr_ff <= 1'b0;
      data_ff <= '0;
      rdy_n_ff <= 1'b1;
      err_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      mode_wr_ff <= mode_wr;
      data_ff <= nxt_data;
      rdy_n_ff <= nxt_rdy_n;
      err_ff <= nxt_err;
    end
  end

  // ==========================================
  // Conversion sequencer
  conv_timer #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .restart(mode_wr_ff),
    .run_cont(run_cont),
    .run_single(run_single),
    .conv_done(conv_done),
    .powered(converter_powered)
  );

  // ==========================================
  // Outputs
  assign dout_rdy_n = dout_ff;
  assign dout_oe_n = cs_n_s;
  assign modulator_reset = mode_wr_ff;
  assign buffer_enable = amp_on;
  assign unipolar_enable = unipolar;
  assign burnout_current_enable = mode_ff[adc_mode_pkg::BURNOUT_BIT] && amp_on;
  assign conv_mode_sel_hi = mode_ff[adc_mode_pkg::MODE_HI_BIT];
  assign conv_mode_sel_lo = mode_ff[adc_mode_pkg::MODE_LO_BIT];
  assign data_ready_n = rdy_n_ff;

  // ==========================================
  // Checks
  sequence mode_rd_load_s;
    cmd_done && cmd_ok && cmd_read && !cmd_cread && (cmd_rs == adc_mode_pkg::RS_MODE);
  endsequence
  sequence mode_wr_end_s;
    wr_done && (rs_ff == adc_mode_pkg::RS_MODE);
  endsequence

  mode_store_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode_wr_end_s |=> mode_ff == $past(rx_byte))
    else $error("mode write not stored");
  mode_msb_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode_rd_load_s |=> ##1 dout_rdy_n == mode_ff[adc_mode_pkg::MODE_HI_BIT])
    else $error("mode read not msb first");
  write_notready_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode_wr_end_s |=> rdy_n_ff && modulator_reset)
    else $error("mode write did not reset and flag not ready");
  conv_store_a: assert property (@(posedge mclk) disable iff (!rstn)
    conv_ok |=> !rdy_n_ff && data_ff == $past(result_fmt))
    else $error("conversion result not stored");
  single_pdown_a: assert property (@(posedge mclk) disable iff (!rstn)
    conv_ok && run_single && !mode_wr |=> !converter_powered)
    else $error("single mode did not power down");
  ready_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    !rdy_n_ff && !rd_data_done && !mode_wr |=> !rdy_n_ff)
    else $error("ready released early");
  burnout_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
    !buffer_enable |-> !burnout_current_enable)
    else $error("burnout on without amplifier");
  pdown_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode_wr_ff && (mode_sel == adc_mode_pkg::MODE_PDOWN) |=> !converter_powered [*2])
    else $error("power down mode still powered");
  bipolar_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    conv_ok && !unipolar && adc_sample == '0 |=> data_ff == adc_mode_pkg::BIPOLAR_ZERO)
    else $error("bipolar zero code wrong");
endmodule
`default_nettype wire

// file: test/host_serial.sv
// Host microcontroller model driving the serial pins
`timescale 1ns/100ps
`default_nettype none
module host_serial (
  // Clock
  input wire logic mclk,
  // Device pins
  input wire logic dout_rdy_n,
  input wire logic dout_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic din,
  // Received value
  output logic rx_done,
  output logic [23:0] rx_word
);
  logic line;
  // ==========================================
  // Released data line shows the inverse of the pin
  assign line = dout_oe_n ? ~dout_rdy_n : dout_rdy_n;
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
    rx_done = 1'b0;
    rx_word = 24'h000000;
  end
  // ==========================================
  // One bit: change after sclk falls, sample at the rise
  task automatic xbit(input logic b, output logic r);
    @(posedge mclk);
    sclk <= 1'b0;
    din <= b;
    repeat (5) @(posedge mclk);
    r = line;
    sclk <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) xbit(b[i], r[i]);
  endtask
  task automatic send_word(input logic [23:0] w, output logic [23:0] r);
    for (int i = 23; i >= 0; i--) xbit(w[i], r[i]);
  endtask
  // ==========================================
  // Framing and result hand-off
  task automatic select();
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic deselect();
    @(posedge mclk);
    din <= 1'b1;
    cs_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task automatic report(input logic [23:0] v);
    @(posedge mclk);
    rx_word <= v;
    rx_done <= 1'b1;
    @(posedge mclk);
    rx_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/test_adc_mode_register_control.sv
// Self-checking bench for the mode register control block
`timescale 1ns/100ps
`default_nettype none
module test_adc_mode_register_control;
  localparam int P = 10;
  logic mclk;
  logic rstn;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_rdy_n;
  logic dout_oe_n;
  logic [23:0] adc_sample;
  logic modulator_reset;
  logic converter_powered;
  logic buffer_enable;
  logic unipolar_enable;
  logic burnout_current_enable;
  logic conv_mode_sel_hi;
  logic conv_mode_sel_lo;
  logic data_ready_n;
  logic rx_done;
  logic [23:0] rx_word;
  logic [23:0] exp_q[$];
  logic [23:0] s;
  logic [23:0] r24;
  logic [7:0] r8;
  logic [7:0] v;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int mr_cnt = 0;
  int mr_cyc = 0;
  int seed = 62;
  int d;
  // ==========================================
  // Design and host model
  adc_mode_register_control #(.OUT_PERIOD_US(1)) adc_mode_register_control_i (
    .mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_rdy_n(dout_rdy_n), .dout_oe_n(dout_oe_n), .adc_sample(adc_sample),
    .modulator_reset(modulator_reset), .converter_powered(converter_powered),
    .buffer_enable(buffer_enable), .unipolar_enable(unipolar_enable),
    .burnout_current_enable(burnout_current_enable), .conv_mode_sel_hi(conv_mode_sel_hi),
    .conv_mode_sel_lo(conv_mode_sel_lo), .data_ready_n(data_ready_n));
  host_serial host_serial_i (
    .mclk(mclk), .dout_rdy_n(dout_rdy_n), .dout_oe_n(dout_oe_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .rx_done(rx_done), .rx_word(rx_word));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ==========================================
  // Reporting
  task automatic fail(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("serial word %h, expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) fail(m);
  endtask
  task automatic summarize();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Cycle count, reset pulses, timeout and result monitor
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (modulator_reset === 1'b1)
    begin
      mr_cnt <= mr_cnt + 1;
      mr_cyc <= cyc;
    end
    if (rx_done === 1'b1)
    begin
      if (exp_q.size() > 0) chk_word(rx_word, exp_q.pop_front());
      else fail("serial result without a note");
    end
    if (cyc == 20000)
    begin
      fail("timeout");
      summarize();
    end
  end
  // ==========================================
  // Host operations
  task automatic wr_reg(input logic [1:0] rs, input logic [7:0] val);
    host_serial_i.select();
    host_serial_i.send_byte({2'b00, rs, 4'h0}, r8);
    host_serial_i.send_byte(val, r8);
    host_serial_i.deselect();
  endtask
  task automatic wr_mode(input logic [7:0] val);
    chk_bit(val[7:6] !== 2'b01, 1'b1, "reserved mode code written");
    wr_reg(adc_mode_pkg::RS_MODE, val & 8'hce);
  endtask
  task automatic rd_mode(input logic [7:0] e);
    exp_q.push_back({16'h0000, e});
    host_serial_i.select();
    chk_bit(dout_oe_n, 1'b0, "data line not driven while selected");
    host_serial_i.send_byte(8'h50, r8);
    host_serial_i.send_byte(8'h00, r8);
    host_serial_i.deselect();
    host_serial_i.report({16'h0000, r8});
  endtask
  task automatic rd_data(input logic [23:0] e);
    exp_q.push_back(e);
    host_serial_i.select();
    host_serial_i.send_byte(8'h70, r8);
    host_serial_i.send_word(24'h000000, r24);
    host_serial_i.deselect();
    host_serial_i.report(r24);
  endtask
  task automatic wait_rdy(input int lim);
    d = 0;
    while (data_ready_n !== 1'b0 && d < lim)
    begin
      @(posedge mclk);
      d++;
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    adc_sample = 24'h000000;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_bit(buffer_enable, 1'b1, "reset buffer");
    chk_bit(burnout_current_enable | unipolar_enable | conv_mode_sel_hi, 1'b0, "reset fields");
    chk_bit(dout_oe_n & dout_rdy_n, 1'b1, "serial line not idle after reset");
    rd_mode(8'h02);
    d = mr_cnt;
    wr_reg(adc_mode_pkg::RS_FILTER, 8'hc0);
    chk_bit(mr_cnt == d, 1'b1, "filter write reset modulator");
    rd_mode(8'h02);
    for (int i = 0; i < 8; i++)
    begin
      v = {4'hc, i[2:0], 1'b0};
      d = mr_cnt;
      wr_mode(v);
      chk_bit(mr_cnt == d + 1, 1'b1, "no modulator reset");
      chk_bit(burnout_current_enable, i[2] & i[0], "burnout");
      chk_bit(unipolar_enable, i[1], "polarity");
      chk_bit(buffer_enable, i[0], "buffer");
      chk_bit(conv_mode_sel_hi & conv_mode_sel_lo, 1'b1, "mode select");
      chk_bit(converter_powered, 1'b0, "powered in power-down");
      rd_mode(v);
    end
    s = $random(seed);
    s[23] = 1'b0;
    adc_sample <= s;
    wr_mode(8'h86);
    chk_bit(conv_mode_sel_hi & ~conv_mode_sel_lo, 1'b1, "single select");
    chk_bit(converter_powered, 1'b1, "single not powered");
    wait_rdy(40);
    chk_bit(cyc - mr_cyc >= 2 * P - 1 && cyc - mr_cyc <= 2 * P + 3, 1'b1, "single timing");
    repeat (4) @(posedge mclk);
    chk_bit(converter_powered, 1'b0, "single stays powered");
    repeat (50) @(posedge mclk);
    chk_bit(data_ready_n, 1'b0, "single result not held");
    rd_data({s[22:0], 1'b0});
    chk_bit(data_ready_n, 1'b1, "ready after read");
    wr_mode(8'h00);
    wait_rdy(40);
    chk_bit(cyc - mr_cyc >= 2 * P - 1 && cyc - mr_cyc <= 2 * P + 3, 1'b1, "first result timing");
    wr_mode(8'h00);
    chk_bit(data_ready_n, 1'b1, "write kept ready");
    chk_bit(conv_mode_sel_hi | conv_mode_sel_lo, 1'b0, "continuous select");
    s = $random(seed);
    adc_sample <= s;
    repeat (3 * P) @(posedge mclk);
    rd_data(s ^ adc_mode_pkg::BIPOLAR_ZERO);
    wait_rdy(P + 2);
    chk_bit(data_ready_n, 1'b0, "no later result");
    exp_q.push_back(s ^ adc_mode_pkg::BIPOLAR_ZERO);
    host_serial_i.select();
    host_serial_i.send_byte(8'h74, r8);
    repeat (P + 3) @(posedge mclk);
    host_serial_i.send_word(24'h580000, r24);
    host_serial_i.deselect();
    host_serial_i.report(r24);
    repeat (10) @(posedge mclk);
    chk_bit(exp_q.size() == 0, 1'b1, "notes left over");
    summarize();
  end
endmodule
`default_nettype wire
